// [core/interrupt_priority_controller.sv]
// interrupt priority controller with stacking, timed disable and AXI4-Lite registers
//
// The AXI4-Lite slave port and the register addresses were decided locally.
`timescale 1ns/100ps

// Notes on behaviour
// - code 7 highest, 1 lowest, 0 disables
// - priority fields other than fault B reset to level four
// - unimplemented bits read zero, ignore writes
// - status bits 11:8 show new level
// - status bits 6:0 show vector minus eight
// - fault B priority resets to zero
// - fields sit at their fixed bit positions
// - nesting disable blocks pre-emption of handlers by user sources
// - request needs both enable and flag
// - flag still set means immediate re-entry
// - return restores pc, low byte, level
// - trap flag set keeps re-entering trap
// - level seven blocks all user sources
// - traps are never masked
// - timed disable blocks levels one to six
// - equal priorities everywhere work as one
module interrupt_priority_controller
   import prio_ctrl_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic awvalid,
   output logic awready,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [ADDR_W-1:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   input wire logic [NUM_SRC-1:0] srcFlag,
   input wire logic [NUM_SRC-1:0] srcEnable,
   input wire logic [NUM_TRAP-1:0] trapEvent,
   input wire logic srlWrite,
   input wire logic [7:0] srlValue,
   input wire logic ackTake,
   input wire logic [PC_W-1:0] pcIn,
   input wire logic retTake,
   input wire logic disiStart,
   input wire logic [TIMED_DISABLE_INSTR_W-1:0] disiCycles,
   output cpu_req_t cpuReq,
   output restore_t restore,
   output logic [3:0] cpuLevel
);

   logic awReady_r;
   logic wReady_r;
   logic awHeld_r;
   logic wHeld_r;
   logic bValid_r;
   logic [1:0] bResp_r;
   logic [ADDR_W-1:0] wrAddr_r;
   logic [31:0] wrData_r;
   logic [3:0] wrStrb_r;
   logic arReady_r;
   logic rValid_r;
   logic [31:0] rData_r;
   logic [1:0] rResp_r;
   logic wrFire;
   logic wrHit;
   logic [31:0] rdVal;
   logic rdHit;

   logic [2:0] userPrio_r [NUM_SRC];
   logic nestDis_r;
   logic [NUM_TRAP-1:0] trapFlag_r;
   logic [NUM_TRAP-1:0] trapClear;
   logic [TIMED_DISABLE_INSTR_W-1:0] disiCount_r;
   logic disiBusy;

   logic [3:0] cpuLevel_r;
   logic [7:0] srl_r;
   frame_t stack_r [STACK_DEPTH];
   logic [3:0] depth_r;
   cpu_req_t cpuReq_r;
   restore_t restore_r;
   logic ackNow;
   logic retNow;
   logic [3:0] popIdx;

   logic [NUM_ENT-1:0] entReq;
   logic [3:0] entLevel [NUM_ENT];
   logic [6:0] entVec [NUM_ENT];
   cpu_req_t best;

   assign awready = awReady_r;
   assign wready = wReady_r;
   assign bvalid = bValid_r;
   assign bresp = bResp_r;
   assign arready = arReady_r;
   assign rvalid = rValid_r;
   assign rdata = rData_r;
   assign rresp = rResp_r;
   assign cpuReq = cpuReq_r;
   assign restore = restore_r;
   assign cpuLevel = cpuLevel_r;

   // bus write: address and data taken in either order, performed once both are held
   // both readies stay low until the response is taken, so a second
   // write can never overtake the one still waiting for bready
   assign wrFire = awHeld_r && wHeld_r && !bValid_r;
   // unmapped addresses answer with an error and change nothing
   assign wrHit = (wrAddr_r == OFS_CAPTURE3) || (wrAddr_r == OFS_PWM) ||
      (wrAddr_r == OFS_FAULTA_CLOCK) || (wrAddr_r == OFS_UART_FAULTB) ||
      (wrAddr_r == OFS_CHARGE_TIME) || (wrAddr_r == OFS_PENDING_STATUS) ||
      (wrAddr_r == OFS_CONTROL_ONE);

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         awReady_r <= 1'b1;
         wReady_r <= 1'b1;
         awHeld_r <= 1'b0;
         wHeld_r <= 1'b0;
         bValid_r <= 1'b0;
         bResp_r <= RESP_OKAY;
         wrAddr_r <= '0;
         wrData_r <= '0;
         wrStrb_r <= '0;
      end else begin
         if (awvalid && awReady_r) begin
            wrAddr_r <= awaddr;
            awReady_r <= 1'b0;
            awHeld_r <= 1'b1;
         end
         if (wvalid && wReady_r) begin
            wrData_r <= wdata;
            wrStrb_r <= wstrb;
            wReady_r <= 1'b0;
            wHeld_r <= 1'b1;
         end
         if (wrFire) begin
            bValid_r <= 1'b1;
            bResp_r <= wrHit ? RESP_OKAY : RESP_SLVERR;
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
         end
         if (bValid_r && bready) begin
            bValid_r <= 1'b0;
            awReady_r <= 1'b1;
            wReady_r <= 1'b1;
         end
      end
   end

   // read mux; every bit not assigned below stays zero
   // the word is captured at the address take: a slow rready then
   // sees a stable snapshot rather than the live status
   always_comb begin
      rdVal = '0;
      rdHit = 1'b0;
      for (int s = 0; s < NUM_SRC; s++) begin
         if (araddr == SRC_OFS[s]) begin
            rdVal[SRC_POS[s] +: 3] = userPrio_r[s];
            rdHit = 1'b1;
         end
      end
      if (araddr == OFS_PENDING_STATUS) begin
         // no offer standing: the field falls back to the running level
         // new level field
         rdVal[STAT_LEVEL_POS +: 4] = cpuReq_r.valid ? cpuReq_r.level : cpuLevel_r;
         rdVal[STAT_VEC_POS +: 7] = cpuReq_r.vector;
         rdHit = 1'b1;
      end
      if (araddr == OFS_CONTROL_ONE) begin
         rdVal[NEST_DIS_POS] = nestDis_r;
         rdVal[TRAP_FLAG_POS +: NUM_TRAP] = trapFlag_r;
         rdHit = 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         arReady_r <= 1'b1;
         rValid_r <= 1'b0;
         rData_r <= '0;
         rResp_r <= RESP_OKAY;
      end else begin
         // one read at a time: arready returns only after rready
         if (arvalid && arReady_r) begin
            arReady_r <= 1'b0;
            rValid_r <= 1'b1;
            rData_r <= rdVal;
            rResp_r <= rdHit ? RESP_OKAY : RESP_SLVERR;
         end
         if (rValid_r && rready) begin
            rValid_r <= 1'b0;
            arReady_r <= 1'b1;
         end
      end
   end

   // priority fields, one per source; the status register is never written
   // a field moves only when the byte lane that holds it is strobed
   for (genvar s = 0; s < NUM_SRC; s++) begin : gPrio
      always_ff @(posedge clk_sys or negedge rst_b) begin
         if (!rst_b) begin
            userPrio_r[s] <= SRC_RESET[s];
         end else if (wrFire && wrAddr_r == SRC_OFS[s] && wrStrb_r[SRC_POS[s] / 8]) begin
            userPrio_r[s] <= wrData_r[SRC_POS[s] +: 3];
         end
      end
   end

   // trap flags: write one to clear, a new event in the same cycle wins
   // so a trap raised while software clears an older one is never lost
   always_comb begin
      trapClear = '0;
      if (wrFire && wrAddr_r == OFS_CONTROL_ONE && wrStrb_r[TRAP_FLAG_POS / 8]) begin
         trapClear = wrData_r[TRAP_FLAG_POS +: NUM_TRAP];
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         trapFlag_r <= '0;
      end else begin
         trapFlag_r <= trapEvent | (trapFlag_r & ~trapClear);
      end
   end

   // nesting disable is the only read-write bit of control one; trap flags only clear on a write of one
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         nestDis_r <= 1'b0;
      end else if (wrFire && wrAddr_r == OFS_CONTROL_ONE && wrStrb_r[NEST_DIS_POS / 8]) begin
         nestDis_r <= wrData_r[NEST_DIS_POS];
      end
   end

   // timed disable counter, one count per clock
   // a new start reloads rather than extends; a zero count cancels
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         disiCount_r <= '0;
      end else if (disiStart) begin
         disiCount_r <= disiCycles;
      end else if (disiCount_r != '0) begin
         disiCount_r <= disiCount_r - TIMED_DISABLE_INSTR_W'(1);
      end
   end

   assign disiBusy = (disiCount_r != '0);

   // per-entry eligibility: traps first, then user sources by ascending vector
   // traps skip cpu level, nesting and timed disable alike
   for (genvar e = 0; e < NUM_ENT; e++) begin : gEnt
      if (e < NUM_TRAP) begin : gTrap
         assign entLevel[e] = TRAP_LEVEL[e];
         assign entVec[e] = TRAP_VEC[e];
         assign entReq[e] = trapFlag_r[e];
      end else begin : gUser
         localparam int S = e - NUM_TRAP;
         assign entLevel[e] = {1'b0, userPrio_r[S]};
         assign entVec[e] = SRC_VEC[S];
         // with nesting disabled, no user source while a handler runs
         assign entReq[e] = (userPrio_r[S] != PRIO_OFF) && srcFlag[S] && srcEnable[S] &&
            ({1'b0, userPrio_r[S]} > cpuLevel_r) &&
            !(disiBusy && userPrio_r[S] <= TIMED_DISABLE_INSTR_TOP_PRIO) &&
            !(nestDis_r && depth_r != 4'h0);
      end
   end

   // winner: highest level; strict compare keeps the earliest entry on a tie
   // levels are four bits wide so trap and user entries compare directly
   always_comb begin
      best = '0;
      for (int e = 0; e < NUM_ENT; e++) begin
         if (entReq[e] && (!best.valid || entLevel[e] > best.level)) begin
            best.valid = 1'b1;
            best.level = entLevel[e];
            best.vector = entVec[e];
         end
      end
   end

   // a return in the same cycle as a take wins; the cpu never issues both
   // a take is honoured only against an offer that is standing
   assign retNow = retTake;
   assign ackNow = ackTake && cpuReq_r.valid && !retTake;
   assign popIdx = depth_r - 4'h1;

   // the offer is registered, so it trails the inputs by one cycle;
   // the withdraw after each take or return hides that lag
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cpuReq_r <= '0;
      end else if (ackNow || retNow) begin
         // offer withdrawn for one cycle so a stale level is never taken
         cpuReq_r <= '0;
      end else begin
         cpuReq_r <= best;
      end
   end

   // a return on an empty stack is ignored, so the depth never wraps
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         depth_r <= 4'h0;
      end else if (retNow && depth_r != 4'h0) begin
         depth_r <= popIdx;
      end else if (ackNow && depth_r != STACK_FULL) begin
         depth_r <= depth_r + 4'h1;
      end
   end

   // frames are kept in flip-flops; a take beyond full depth is not stacked
   // limitation: the level still rises, so software must bound nesting
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < STACK_DEPTH; i++) begin
            stack_r[i] <= '0;
         end
      end else if (ackNow && depth_r != STACK_FULL) begin
         stack_r[depth_r[2:0]] <= '{pc: pcIn, status_low_byte: srl_r, level: cpuLevel_r};
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cpuLevel_r <= 4'h0;
         srl_r <= 8'h00;
         restore_r <= '0;
      end else begin
         restore_r.valid <= 1'b0;
         // restore pulses one cycle; the frame itself stays for reading
         if (retNow && depth_r != 4'h0) begin
            restore_r.valid <= 1'b1;
            restore_r.frame <= stack_r[popIdx[2:0]];
            cpuLevel_r <= stack_r[popIdx[2:0]].level;
            srl_r <= stack_r[popIdx[2:0]].status_low_byte;
         end else if (ackNow) begin
            // the low byte holds three level bits, so a trap shows seven
            cpuLevel_r <= cpuReq_r.level;
            srl_r[SRL_IPL_POS +: 3] <= cpuReq_r.level[3] ? 3'h7 : cpuReq_r.level[2:0];
         end else if (srlWrite) begin
            // a low byte write can never lift the level into trap range
            // level from low byte top bits
            srl_r <= srlValue;
            cpuLevel_r <= {1'b0, srlValue[SRL_IPL_POS +: 3]};
         end
      end
   end

endmodule

// [core/prio_ctrl_pkg.sv]
// constants, register map and carrier types of the interrupt priority controller
package prio_ctrl_pkg;

   // sizes
   localparam int NUM_SRC = 7;
   localparam int NUM_TRAP = 4;
   localparam int NUM_ENT = NUM_TRAP + NUM_SRC;
   localparam int STACK_DEPTH = 8;
   localparam int ADDR_W = 8;
   localparam int PC_W = 24;
   localparam int TIMED_DISABLE_INSTR_W = 14;

   // register byte offsets
   localparam logic [ADDR_W-1:0] OFS_CAPTURE3 = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_PWM = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_FAULTA_CLOCK = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_UART_FAULTB = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_CHARGE_TIME = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_PENDING_STATUS = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_CONTROL_ONE = 8'h18;

   // source indices, ordered by ascending vector number
   localparam int SRC_CAPTURE3 = 0;
   localparam int SRC_PWM = 1;
   localparam int SRC_FAULT_A = 2;
   localparam int SRC_CLOCK_CAL = 3;
   localparam int SRC_UART_ERR = 4;
   localparam int SRC_FAULT_B = 5;
   localparam int SRC_CHARGE_TIME = 6;

   // field placement of each source priority
   localparam logic [ADDR_W-1:0] SRC_OFS [NUM_SRC] = '{OFS_CAPTURE3, OFS_PWM,
      OFS_FAULTA_CLOCK, OFS_FAULTA_CLOCK, OFS_UART_FAULTB, OFS_UART_FAULTB, OFS_CHARGE_TIME};
   localparam int SRC_POS [NUM_SRC] = '{4, 4, 12, 8, 4, 0, 4};

   // reset values
   localparam logic [2:0] PRIO_RESET = 3'h4;
   localparam logic [2:0] FAULTB_RESET = 3'h0;
   localparam logic [2:0] SRC_RESET [NUM_SRC] = '{PRIO_RESET, PRIO_RESET, PRIO_RESET,
      PRIO_RESET, PRIO_RESET, FAULTB_RESET, PRIO_RESET};

   // vector codes (vector minus eight); values are arbitrary
   localparam logic [6:0] SRC_VEC [NUM_SRC] = '{7'h25, 7'h35, 7'h3C, 7'h3E, 7'h41,
      7'h42, 7'h4E};
   localparam logic [6:0] TRAP_VEC [NUM_TRAP] = '{7'h00, 7'h01, 7'h02, 7'h03};
   localparam logic [3:0] TRAP_LEVEL [NUM_TRAP] = '{4'hE, 4'hD, 4'hC, 4'hB};

   // status and control field positions
   localparam int STAT_LEVEL_POS = 8;
   localparam int STAT_VEC_POS = 0;
   localparam int NEST_DIS_POS = 15;
   localparam int TRAP_FLAG_POS = 0;
   localparam int SRL_IPL_POS = 5;

   // level limits
   localparam logic [2:0] PRIO_OFF = 3'h0;
   localparam logic [2:0] TIMED_DISABLE_INSTR_TOP_PRIO = 3'h6;
   localparam logic [3:0] STACK_FULL = 4'h8;

   // bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic valid;
      logic [3:0] level;
      logic [6:0] vector;
   } cpu_req_t;

   typedef struct packed {
      logic [PC_W-1:0] pc;
      logic [7:0] status_low_byte;
      logic [3:0] level;
   } frame_t;

   typedef struct packed {
      logic valid;
      frame_t frame;
   } restore_t;

endpackage

// [testbench/cpu_core_model.sv]
// cpu stand-in that takes a standing offer after a set lag
`timescale 1ns/100ps
module cpu_core_model
   import prio_ctrl_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_b,
   input cpu_req_t cpuReq,
   input wire logic autoAck,
   input wire logic [3:0] ackLag,
   output logic ackTake,
   output logic [PC_W-1:0] pcIn
);
   logic [3:0] waitCnt_r;
   // one-cycle take, never two in a row: the offer drops after a take
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ackTake <= 1'b0;
         waitCnt_r <= 4'h0;
         pcIn <= 24'h000100;
      end else begin
         ackTake <= 1'b0;
         if (!cpuReq.valid || !autoAck || ackTake)
            waitCnt_r <= 4'h0;
         else if (waitCnt_r < ackLag)
            waitCnt_r <= waitCnt_r + 4'h1;
         else begin
            ackTake <= 1'b1;
            pcIn <= pcIn + 24'h000004;
         end
      end
   end
endmodule

// [testbench/interrupt_priority_controller_tb.sv]
// self-checking bench for the interrupt priority controller
`timescale 1ns/100ps
module interrupt_priority_controller_tb
   import prio_ctrl_pkg::*;
;
   typedef struct packed {
      logic [7:0] a;
      logic [31:0] d;
      logic [3:0] s;
      logic [15:0] e;
      logic [1:0] r;
   } row_t;
   logic clk_sys = 1'b0, rst_b = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, srlWrite = 1'b0, retTake = 1'b0, disiStart = 1'b0;
   logic autoAck = 1'b0, ackTake, awready, wready, bvalid, arready, rvalid;
   logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata, rdv;
   logic [3:0] wstrb = '0, ackLag = '0, cpuLevel;
   logic [1:0] bresp, rresp, resp;
   logic [NUM_SRC-1:0] srcFlag = '0, srcEnable = '0;
   logic [NUM_TRAP-1:0] trapEvent = '0;
   logic [7:0] srlValue = '0;
   logic [PC_W-1:0] pcIn;
   logic [TIMED_DISABLE_INSTR_W-1:0] disiCycles = '0;
   cpu_req_t cpuReq;
   restore_t restore;
   int err_count = 0, compares = 0;
   localparam row_t ROWS [11] = '{'{8'h00, 32'hFFFFFFFF, 4'hF, 16'h0070, 2'h0},
      '{8'h04, 32'hFFFFFFFF, 4'hF, 16'h0070, 2'h0}, '{8'h08, 32'hFFFFFFFF, 4'hF, 16'h7700, 2'h0},
      '{8'h0C, 32'hFFFFFFFF, 4'hF, 16'h0077, 2'h0}, '{8'h10, 32'hFFFFFFFF, 4'hF, 16'h0070, 2'h0},
      '{8'h08, 32'h00000000, 4'h1, 16'h7700, 2'h0}, '{8'h08, 32'h00000000, 4'h2, 16'h0000, 2'h0},
      '{8'h14, 32'hFFFFFFFF, 4'hF, 16'h0000, 2'h0}, '{8'h18, 32'h00008000, 4'hF, 16'h8000, 2'h0},
      '{8'h18, 32'h00000000, 4'hF, 16'h0000, 2'h0}, '{8'h1C, 32'hFFFFFFFF, 4'hF, 16'h0000, 2'h2}};
   localparam logic [31:0] RST_EXP [7] = '{32'h40, 32'h40, 32'h4400, 32'h40, 32'h40, 32'h0,
      32'h0};

   interrupt_priority_controller dut (.clk_sys, .rst_b, .awvalid, .awready, .awaddr, .wvalid,
      .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid,
      .rready, .rdata, .rresp, .srcFlag, .srcEnable, .trapEvent, .srlWrite, .srlValue,
      .ackTake, .pcIn, .retTake, .disiStart, .disiCycles, .cpuReq, .restore, .cpuLevel);
   cpu_core_model cpu (.clk_sys, .rst_b, .cpuReq, .autoAck, .ackLag, .ackTake, .pcIn);

   initial begin
      forever #50 clk_sys = ~clk_sys;
   end

   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask

   function automatic logic [31:0] offer(input logic [3:0] l, input logic [6:0] v);
      return {20'h0, 1'b1, l, v};
   endfunction

   task automatic wait_n(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   task automatic reset_dut(input int n);
      rst_b <= 1'b0;
      wait_n(n);
      rst_b <= 1'b1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
         output logic [1:0] r);
      @(posedge clk_sys);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge clk_sys);
         if (awvalid && awready)
            awvalid <= 1'b0;
         if (wvalid && wready)
            wvalid <= 1'b0;
         if (bvalid) begin
            r = bresp;
            bready <= 1'b0;
            break;
         end
      end
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk_sys);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge clk_sys);
         if (arvalid && arready)
            arvalid <= 1'b0;
         if (rvalid) begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            break;
         end
      end
   endtask

   task automatic ret_pulse;
      retTake <= 1'b1;
      @(posedge clk_sys);
      retTake <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial begin
      wait_n(6000);
      err_count++;
      end_sim();
   end

   initial begin
      reset_dut(16);
      foreach (ROWS[i]) begin
         wr(ROWS[i].a, ROWS[i].d, ROWS[i].s, resp);
         chk("bresp", 32'(resp), 32'(ROWS[i].r));
         rd(ROWS[i].a, rdv, resp);
         chk("rresp", 32'(resp), 32'(ROWS[i].r));
         if (ROWS[i].r == RESP_OKAY)
            chk("rdata", rdv, 32'(ROWS[i].e));
      end
      $display("test register table done");
      reset_dut(4);
      foreach (RST_EXP[i]) begin
         rd(8'(4 * i), rdv, resp);
         chk("reset value", rdv, RST_EXP[i]);
      end
      $display("test reset values done");
      // fault B lifted to code one, flagged alone with uart at code zero
      wr(OFS_UART_FAULTB, 32'h1, 4'hF, resp);
      srcEnable <= 7'h7E;
      srcFlag <= 7'h30;
      wait_n(4);
      chk("code one", 32'(cpuReq), offer(4'h1, SRC_VEC[SRC_FAULT_B]));
      // capture3 flagged but not enabled; fault B below the tie
      srcFlag <= 7'h7F;
      wait_n(4);
      chk("tie offer", 32'(cpuReq), offer(4'h4, SRC_VEC[SRC_PWM]));
      rd(OFS_PENDING_STATUS, rdv, resp);
      chk("status", rdv, {20'h0, 4'h4, 1'b0, SRC_VEC[SRC_PWM]});
      ackLag <= 4'h3;
      autoAck <= 1'b1;
      wait_n(10);
      chk("level", 32'(cpuLevel), 32'h4);
      chk("no offer", 32'(cpuReq.valid), 32'h0);
      $display("test tie and take done");
      ackLag <= 4'h0;
      wr(OFS_FAULTA_CLOCK, 32'h4700, 4'hF, resp);
      wait_n(6);
      chk("preempt", 32'(cpuLevel), 32'h7);
      autoAck <= 1'b0;
      wait_n(2);
      ret_pulse();
      chk("restore", 32'({restore.valid, restore.frame.level}), 32'h14);
      chk("pc", 32'(restore.frame.pc), 32'(pcIn));
      chk("srl", 32'(restore.frame.status_low_byte), 32'h80);
      @(posedge clk_sys);
      chk("reentry", 32'(cpuReq), offer(4'h7, SRC_VEC[SRC_CLOCK_CAL]));
      $display("test return done");
      srlWrite <= 1'b1;
      srlValue <= 8'hE0;
      @(posedge clk_sys);
      srlWrite <= 1'b0;
      srcFlag <= 7'h08;
      wait_n(4);
      chk("masked", 32'(cpuReq.valid), 32'h0);
      trapEvent <= 4'h4;
      @(posedge clk_sys);
      trapEvent <= 4'h0;
      wait_n(3);
      chk("trap", 32'(cpuReq), offer(TRAP_LEVEL[2], TRAP_VEC[2]));
      autoAck <= 1'b1;
      wait_n(4);
      autoAck <= 1'b0;
      wait_n(3);
      chk("trap again", 32'(cpuReq), offer(TRAP_LEVEL[2], TRAP_VEC[2]));
      wr(OFS_CONTROL_ONE, 32'h4, 4'hF, resp);
      wait_n(3);
      chk("trap cleared", 32'(cpuReq.valid), 32'h0);
      $display("test mask and trap done");
      reset_dut(3);
      wr(OFS_PWM, 32'h60, 4'hF, resp);
      wr(OFS_FAULTA_CLOCK, 32'h4700, 4'hF, resp);
      disiCycles <= 14'h28;
      disiStart <= 1'b1;
      @(posedge clk_sys);
      disiStart <= 1'b0;
      srcFlag <= 7'h02;
      wait_n(10);
      chk("timed_disable_instr block", 32'(cpuReq.valid), 32'h0);
      srcFlag <= 7'h0A;
      wait_n(4);
      chk("timed_disable_instr pass", 32'(cpuReq), offer(4'h7, SRC_VEC[SRC_CLOCK_CAL]));
      srcFlag <= 7'h02;
      wait_n(40);
      chk("timed_disable_instr end", 32'(cpuReq), offer(4'h6, SRC_VEC[SRC_PWM]));
      $display("test timed disable done");
      wr(OFS_CONTROL_ONE, 32'h8000, 4'hF, resp);
      autoAck <= 1'b1;
      wait_n(5);
      autoAck <= 1'b0;
      srcFlag <= 7'h0A;
      wait_n(5);
      chk("no nesting", 32'(cpuReq.valid), 32'h0);
      ret_pulse();
      wait_n(2);
      chk("after return", 32'(cpuReq), offer(4'h7, SRC_VEC[SRC_CLOCK_CAL]));
      $display("test nesting disable done");
      end_sim();
   end
endmodule

// [testbench/prio_ctrl_sva.sv]
// port-level checks of the interrupt priority controller
`timescale 1ns/100ps
module prio_ctrl_sva
   import prio_ctrl_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic rvalid,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic [NUM_SRC-1:0] srcFlag,
   input wire logic [NUM_SRC-1:0] srcEnable,
   input wire logic [NUM_TRAP-1:0] trapEvent,
   input wire logic srlWrite,
   input wire logic [7:0] srlValue,
   input wire logic ackTake,
   input wire logic retTake,
   input wire logic disiStart,
   input wire logic [TIMED_DISABLE_INSTR_W-1:0] disiCycles,
   input cpu_req_t cpuReq,
   input restore_t restore,
   input wire logic [3:0] cpuLevel
);
   logic [TIMED_DISABLE_INSTR_W-1:0] disiLeft_r;
   logic userOffer;
   logic [2:0] srlTop;
   assign userOffer = cpuReq.valid && cpuReq.vector > 7'h03;
   assign srlTop = srlValue[7:5];
   // own copy of the disable window, margin of two for the offer lag
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b)
         disiLeft_r <= '0;
      else if (disiStart)
         disiLeft_r <= disiCycles;
      else if (disiLeft_r != '0)
         disiLeft_r <= disiLeft_r - 1'b1;
   end
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);
   property p_userAbove;
      userOffer |-> cpuReq.level > $past(cpuLevel);
   endproperty
   a_userAbove: assert property (p_userAbove) else $error("offer not above level");
   property p_trapNow;
      |trapEvent |-> ##[1:3] (cpuReq.valid && cpuReq.level > 4'hA);
   endproperty
   a_trapNow: assert property (p_trapNow) else $error("trap not offered");
   property p_needFlag;
      userOffer |-> |($past(srcFlag) & $past(srcEnable));
   endproperty
   a_needFlag: assert property (p_needFlag) else $error("offer without request");
   property p_srlLevel;
      srlWrite && !retTake && !(ackTake && cpuReq.valid) |=> cpuLevel == {1'b0, $past(srlTop)};
   endproperty
   a_srlLevel: assert property (p_srlLevel) else $error("level not from low byte");
   property p_restore;
      restore.valid |-> $past(retTake) && cpuLevel == restore.frame.level && !cpuReq.valid;
   endproperty
   a_restore: assert property (p_restore) else $error("bad return");
   property p_timed_disable_instr;
      $past(disiLeft_r) > 14'h2 && userOffer |-> cpuReq.level == 4'h7;
   endproperty
   a_timed_disable_instr: assert property (p_timed_disable_instr) else $error("offer inside disable window");
   property p_take;
      ackTake && cpuReq.valid && !retTake |=> !cpuReq.valid && cpuLevel == $past(cpuReq.level);
   endproperty
   a_take: assert property (p_take) else $error("take did not raise level");
   property p_resv;
      rvalid && rresp == RESP_OKAY |-> rdata[31:16] == 16'h0;
   endproperty
   a_resv: assert property (p_resv) else $error("reserved bits set");
   c_trap: cover property (cpuReq.valid && cpuReq.level > 4'hA);
   c_restore: cover property (restore.valid);
   c_timed_disable_instr: cover property (disiLeft_r > 14'h2 && userOffer);
endmodule

bind interrupt_priority_controller prio_ctrl_sva watch (.clk_sys, .rst_b, .rvalid, .rdata,
   .rresp, .srcFlag, .srcEnable, .trapEvent, .srlWrite, .srlValue, .ackTake, .retTake,
   .disiStart, .disiCycles, .cpuReq, .restore, .cpuLevel);
